/* cmo_defs.vh */
`ifndef CMO_DEFS_VH
`define CMO_DEFS_VH

// Operation codes on the command port
`define CMO_OP_W            3
`define CMO_OP_BLK_INV      3'h0
`define CMO_OP_SEG_WR       3'h1
`define CMO_OP_SEG_RD       3'h2
`define CMO_OP_TLB_INV      3'h3
`define CMO_OP_TLB_SYNC     3'h4
`define CMO_OP_TLB_INV_ALL  3'h5

// Effective address set index, big-endian bits 14..19 = little-endian 17..12
`define CMO_EA_SET_HI       17
`define CMO_EA_SET_LO       12
`define CMO_SET_W           6
`define CMO_NUM_SETS        64

// Segment register select, top four bits of the effective address
`define CMO_SEG_HI          31
`define CMO_SEG_LO          28
`define CMO_SEG_CNT         16
`define CMO_SEG_IDX_W       4
// Direct-store flag of a segment register (T bit, big-endian bit 0)
`define CMO_SEG_T_BIT       31

// Data cache block states
`define CMO_ST_INVALID      2'h0
`define CMO_ST_EXCL         2'h1
`define CMO_ST_MOD          2'h2

// Register offsets (word addresses on the register port)
`define CMO_ADDR_W          4
`define CMO_REG_CONFIG      4'h0
`define CMO_REG_MSTATE      4'h1
`define CMO_REG_STATUS      4'h2
`define CMO_REG_MASK        4'h3
`define CMO_REG_RESULT      4'h4

// Field positions
`define CMO_CFG_ABE_BIT     0
`define CMO_CFG_READ_INSTR_SEGMENT_SEL_BIT   1
`define CMO_MS_IR_BIT       0
`define CMO_MS_DR_BIT       1

// Status bits
`define CMO_EV_W            5
`define CMO_EV_DONE         0
`define CMO_EV_BAT_DSI      1
`define CMO_EV_TLB_DSI      2
`define CMO_EV_ILLEGAL      3
`define CMO_EV_SYNC_DONE    4

`define CMO_ZERO32          32'h0000_0000
`define CMO_ZERO_EV         5'h00

`endif

/* cmo_maint.v */
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "cmo_defs.vh"

module cmo_maint (
  input  wire        mclk,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire [31:0] op_ea,
  input  wire [31:0] op_data,
  input  wire        xlate_bat_hit,
  input  wire        xlate_bat_store_ok,
  input  wire        xlate_tlb_store_ok,
  input  wire        dc_hit,
  input  wire [1:0]  dc_state,
  input  wire        xlate_invalidate_sync_in,
  input  wire        tlb_fill_en,
  input  wire [5:0]  tlb_fill_set,
  input  wire [3:0]  tlb_fill_ways,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         op_busy,
  output reg         op_done,
  output reg  [31:0] xlate_ea,
  output reg         xlate_req,
  output reg         xlate_is_store,
  output reg         dc_inv_req,
  output reg  [1:0]  dc_new_state,
  output reg         bus_broadcast,
  output reg         dsi_exc,
  output reg         prog_illegal_exc,
  output reg  [31:0] seg_rd_data,
  output reg         irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_XLAT = 2'h1;
  localparam ST_SYNC = 2'h2;

  reg  [1:0]            state_reg;
  reg  [31:0]           ea_reg;
  reg  [1:0]            impl_config_reg;
  reg  [1:0]            machine_state_reg;
  reg  [`CMO_EV_W-1:0]  status_reg;
  reg  [`CMO_EV_W-1:0]  mask_reg;
  reg  [31:0]           last_seg_reg;
  reg                   sync_m_reg;
  reg                   sync_s_reg;
  reg  [`CMO_EV_W-1:0]  ev_next;

  wire                  address_broadcast_enable = impl_config_reg[`CMO_CFG_ABE_BIT];
  wire                  read_instr_segment_sel   = impl_config_reg[`CMO_CFG_READ_INSTR_SEGMENT_SEL_BIT];
  wire                  take_op                  = op_valid && (state_reg == ST_IDLE);
  wire [3:0]            seg_idx;
  wire [31:0]           seg_rd;
  wire [31:0]           data_seg;
  wire                  seg_wr_en;
  wire                  tlb_inv_en;
  wire                  direct_store;

  function [5:0] ea_set;
    input [31:0] ea;
    begin
      ea_set = ea[`CMO_EA_SET_HI:`CMO_EA_SET_LO];
    end
  endfunction

  function [3:0] ea_seg;
    input [31:0] ea;
    begin
      ea_seg = ea[`CMO_SEG_HI:`CMO_SEG_LO];
    end
  endfunction

  // Segment moves decode without looking at machine_state_reg
  assign seg_wr_en  = take_op && (op_code == `CMO_OP_SEG_WR);
  assign tlb_inv_en = take_op && (op_code == `CMO_OP_TLB_INV);
  assign seg_idx    = take_op ? ea_seg(op_ea) : ea_seg(ea_reg);
  assign direct_store = data_seg[`CMO_SEG_T_BIT];

  cmo_seg_file u_seg (
    .mclk          (mclk),
    .rst           (rst),
    .wr_en         (seg_wr_en),
    .wr_idx        (ea_seg(op_ea)),
    .wr_data       (op_data),
    .rd_idx        (seg_idx),
    .rd_instr_side (read_instr_segment_sel),
    .rd_data       (seg_rd),
    .data_seg      (data_seg)
  );

  cmo_tlb_valid u_tlb (
    .mclk      (mclk),
    .rst       (rst),
    .inv_en    (tlb_inv_en),
    .inv_set   (ea_set(op_ea)),
    .fill_en   (tlb_fill_en),
    .fill_set  (tlb_fill_set),
    .fill_ways (tlb_fill_ways),
    .set_valid ()
  );

  // Sync input is asynchronous to the core; two stages before use
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_m_reg <= 1'b0;
      sync_s_reg <= 1'b0;
    end else begin
      sync_m_reg <= xlate_invalidate_sync_in;
      sync_s_reg <= sync_m_reg;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg        <= ST_IDLE;
      ea_reg           <= `CMO_ZERO32;
      op_busy          <= 1'b0;
      op_done          <= 1'b0;
      xlate_ea         <= `CMO_ZERO32;
      xlate_req        <= 1'b0;
      xlate_is_store   <= 1'b0;
      dc_inv_req       <= 1'b0;
      dc_new_state     <= `CMO_ST_INVALID;
      bus_broadcast    <= 1'b0;
      dsi_exc          <= 1'b0;
      prog_illegal_exc <= 1'b0;
      seg_rd_data      <= `CMO_ZERO32;
      ev_next          <= `CMO_ZERO_EV;
    end else begin
      op_done          <= 1'b0;
      xlate_req        <= 1'b0;
      dc_inv_req       <= 1'b0;
      bus_broadcast    <= 1'b0;
      dsi_exc          <= 1'b0;
      prog_illegal_exc <= 1'b0;
      ev_next          <= `CMO_ZERO_EV;
      case (state_reg)
        ST_IDLE: begin
          if (op_valid) begin
            ea_reg <= op_ea;
            case (op_code)
              `CMO_OP_BLK_INV: begin
                // Translation is requested as a store; cache is untouched until it answers
                xlate_ea       <= op_ea;
                xlate_req      <= 1'b1;
                xlate_is_store <= 1'b1;
                op_busy        <= 1'b1;
                state_reg      <= ST_XLAT;
              end
              `CMO_OP_SEG_RD: begin
                seg_rd_data <= seg_rd;
                op_done     <= 1'b1;
                ev_next[`CMO_EV_DONE] <= 1'b1;
              end
              `CMO_OP_TLB_SYNC: begin
                op_busy   <= 1'b1;
                state_reg <= ST_SYNC;
              end
              `CMO_OP_TLB_INV_ALL: begin
                prog_illegal_exc <= 1'b1;
                op_done          <= 1'b1;
                ev_next[`CMO_EV_ILLEGAL] <= 1'b1;
              end
              default: begin
                op_done <= 1'b1;
                ev_next[`CMO_EV_DONE] <= 1'b1;
              end
            endcase
          end
        end
        ST_XLAT: begin
          // Translation answers in the same cycle that xlate_req is high
          state_reg <= ST_IDLE;
          op_busy   <= 1'b0;
          op_done   <= 1'b1;
          if (xlate_bat_hit && !xlate_bat_store_ok) begin
            dsi_exc <= 1'b1;
            ev_next[`CMO_EV_BAT_DSI] <= 1'b1;
          end else if (!xlate_bat_hit && !xlate_tlb_store_ok) begin
            dsi_exc <= 1'b1;
            ev_next[`CMO_EV_TLB_DSI] <= 1'b1;
          end else begin
            ev_next[`CMO_EV_DONE] <= 1'b1;
            // No enable or lock gating: the invalidate proceeds regardless
            if (!direct_store && dc_hit && dc_state != `CMO_ST_INVALID) begin
              dc_inv_req   <= 1'b1;
              dc_new_state <= `CMO_ST_INVALID;
            end
            if (!direct_store)
              bus_broadcast <= address_broadcast_enable;
          end
        end
        ST_SYNC: begin
          if (!sync_s_reg) begin
            state_reg <= ST_IDLE;
            op_busy   <= 1'b0;
            op_done   <= 1'b1;
            ev_next[`CMO_EV_SYNC_DONE] <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          op_busy   <= 1'b0;
        end
      endcase
    end
  end

  // Register port; a status event wins over a same-cycle write-one clear
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      impl_config_reg   <= 2'h0;
      machine_state_reg <= 2'h0;
      status_reg        <= `CMO_ZERO_EV;
      mask_reg          <= `CMO_ZERO_EV;
      reg_rdata         <= `CMO_ZERO32;
      irq               <= 1'b0;
      last_seg_reg      <= `CMO_ZERO32;
    end else begin
      if (reg_wr && reg_addr == `CMO_REG_CONFIG)
        impl_config_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `CMO_REG_MSTATE)
        machine_state_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `CMO_REG_MASK)
        mask_reg <= reg_wdata[`CMO_EV_W-1:0];
      if (reg_wr && reg_addr == `CMO_REG_STATUS)
        status_reg <= (status_reg & ~reg_wdata[`CMO_EV_W-1:0]) | ev_next;
      else
        status_reg <= status_reg | ev_next;
      if (op_done)
        last_seg_reg <= seg_rd_data;
      irq <= |(status_reg & mask_reg);
      reg_rdata <= `CMO_ZERO32;
      if (reg_rd) begin
        case (reg_addr)
          `CMO_REG_CONFIG: reg_rdata <= {30'h0000_0000, impl_config_reg};
          `CMO_REG_MSTATE: reg_rdata <= {30'h0000_0000, machine_state_reg};
          `CMO_REG_STATUS: reg_rdata <= {27'h000_0000, status_reg};
          `CMO_REG_MASK:   reg_rdata <= {27'h000_0000, mask_reg};
          `CMO_REG_RESULT: reg_rdata <= last_seg_reg;
          default:         reg_rdata <= `CMO_ZERO32;
        endcase
      end
    end
  end
endmodule

/* cmo_maint_bench.sv */
`timescale 1ns/1ns
`include "cmo_defs.vh"
module cmo_maint_bench;
  typedef struct packed {
    logic [2:0]  code;
    logic [31:0] ea;
    logic [31:0] dat;
    logic [3:0]  ans;
    logic [1:0]  st;
    logic [3:0]  exp;
  } cmo_row_t;
  reg         mclk;
  reg         rst;
  reg         op_valid;
  reg  [2:0]  op_code;
  reg  [31:0] op_ea;
  reg  [31:0] op_data;
  reg  [3:0]  ans;
  reg  [1:0]  dc_state;
  reg         sync_in;
  reg  [3:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  wire [31:0] seg_rd_data;
  wire [1:0]  dc_new_state;
  wire        op_busy, op_done, dsi, inv, bcast, ill, irq;
  integer     miscompares, num_checks, i, p;
  cmo_row_t   rows [0:10];
  cmo_row_t   r;
  cmo_maint dut_u (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_ea(op_ea), .op_data(op_data),
    .xlate_bat_hit(ans[3]), .xlate_bat_store_ok(ans[2]), .xlate_tlb_store_ok(ans[1]), .dc_hit(ans[0]),
    .dc_state(dc_state), .xlate_invalidate_sync_in(sync_in), .tlb_fill_en(1'b0), .tlb_fill_set(6'h00),
    .tlb_fill_ways(4'h0), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_busy(op_busy), .op_done(op_done), .xlate_ea(), .xlate_req(), .xlate_is_store(),
    .dc_inv_req(inv), .dc_new_state(dc_new_state), .bus_broadcast(bcast), .dsi_exc(dsi),
    .prog_illegal_exc(ill), .seg_rd_data(seg_rd_data), .irq(irq));
  always #10 mclk = ~mclk;
  task tally_and_finish;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task reg_read(input logic [3:0] a, input logic [31:0] e);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(reg_rdata, e);
    end
  endtask
  // Answers are held from the request through the sampling cycle
  task run_op(input cmo_row_t t);
    integer k;
    begin
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code <= t.code;
      op_ea <= t.ea;
      op_data <= t.dat;
      ans <= t.ans;
      dc_state <= t.st;
      @(posedge mclk);
      op_valid <= 1'b0;
      k = 0;
      do begin
        @(negedge mclk);
        k = k + 1;
      end while (op_done !== 1'b1 && k < 20);
      chk(32'({op_done, dsi, inv, bcast, ill}), 32'({1'b1, t.exp}));
      if (inv === 1'b1) chk(32'(dc_new_state), 32'(`CMO_ST_INVALID));
      if (t.code == `CMO_OP_SEG_RD) chk(seg_rd_data, t.dat);
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    {mclk, op_valid, op_code, op_ea, op_data, ans, dc_state, sync_in} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    rst = 1'b1;
    miscompares = 0;
    num_checks = 0;
    rows[0] = '{`CMO_OP_BLK_INV, 32'h0000_1000, 32'h0, 4'b1101, `CMO_ST_MOD, 4'b0110};
    rows[1] = '{`CMO_OP_BLK_INV, 32'h0000_2040, 32'h0, 4'b0011, `CMO_ST_EXCL, 4'b0110};
    rows[2] = '{`CMO_OP_BLK_INV, 32'h0000_3000, 32'h0, 4'b0010, `CMO_ST_INVALID, 4'b0010};
    rows[3] = '{`CMO_OP_BLK_INV, 32'h0000_1000, 32'h0, 4'b1001, `CMO_ST_MOD, 4'b1000};
    rows[4] = '{`CMO_OP_BLK_INV, 32'h0000_1000, 32'h0, 4'b0001, `CMO_ST_MOD, 4'b1000};
    rows[5] = '{`CMO_OP_SEG_WR, 32'h2000_0000, 32'h8000_0005, 4'h0, 2'h0, 4'h0};
    rows[6] = '{`CMO_OP_SEG_RD, 32'h2000_0000, 32'h8000_0005, 4'h0, 2'h0, 4'h0};
    rows[7] = '{`CMO_OP_BLK_INV, 32'h2000_0100, 32'h0, 4'b1101, `CMO_ST_MOD, 4'h0};
    rows[8] = '{`CMO_OP_TLB_INV, 32'h0003_F000, 32'h0, 4'h0, 2'h0, 4'h0};
    rows[9] = '{`CMO_OP_TLB_INV_ALL, 32'h0, 32'h0, 4'h0, 2'h0, 4'b0001};
    rows[10] = '{3'h6, 32'h0, 32'h0, 4'h0, 2'h0, 4'h0};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    reg_write(`CMO_REG_CONFIG, 32'h0000_0001);
    // Second pass repeats everything with both translation enables set
    for (p = 0; p < 2; p = p + 1) begin
      reg_write(`CMO_REG_MSTATE, p ? 32'h0000_0003 : 32'h0000_0000);
      for (i = 0; i < 11; i = i + 1) run_op(rows[i]);
    end
    reg_write(`CMO_REG_CONFIG, 32'h0000_0002);
    r = rows[0];
    r.exp = 4'b0100;
    run_op(r);
    run_op(rows[6]);
    reg_read(`CMO_REG_CONFIG, 32'h0000_0002);
    // Whole-TLB clear: every set index in turn, then one synchronise with the sync input idle
    r = rows[8];
    for (i = 0; i < `CMO_NUM_SETS; i = i + 1) begin
      r.ea = 32'(i) << `CMO_EA_SET_LO;
      run_op(r);
    end
    run_op('{`CMO_OP_TLB_SYNC, 32'h0, 32'h0, 4'h0, 2'h0, 4'h0});
    sync_in <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= `CMO_OP_TLB_SYNC;
    @(posedge mclk);
    op_valid <= 1'b0;
    repeat (8) @(negedge mclk);
    chk(32'(op_busy), 32'h0000_0001);
    sync_in <= 1'b0;
    i = 0;
    do begin
      @(negedge mclk);
      i = i + 1;
    end while (op_done !== 1'b1 && i < 20);
    chk(32'(op_done), 32'h0000_0001);
    reg_read(`CMO_REG_STATUS, 32'h0000_001F);
    chk(32'(irq), 32'h0000_0000);
    reg_write(`CMO_REG_MASK, 32'h0000_0008);
    repeat (2) @(negedge mclk);
    chk(32'(irq), 32'h0000_0001);
    reg_write(`CMO_REG_STATUS, 32'h0000_001F);
    reg_read(`CMO_REG_STATUS, 32'h0000_0000);
    reg_read(`CMO_REG_RESULT, 32'h8000_0005);
    reg_read(4'hF, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    chk(32'({op_busy, op_done, dsi, inv, bcast, ill, irq}), 32'h0000_0000);
    @(posedge mclk);
    rst <= 1'b0;
    reg_read(`CMO_REG_CONFIG, 32'h0000_0000);
    tally_and_finish;
  end
endmodule

/* cmo_maint_chk.sv */
`timescale 1ns/1ns
`include "cmo_defs.vh"
module cmo_maint_chk (
  input logic        mclk,
  input logic        rst,
  input logic        op_valid,
  input logic [2:0]  op_code,
  input logic [31:0] op_ea,
  input logic        xlate_bat_hit,
  input logic        xlate_bat_store_ok,
  input logic        dc_hit,
  input logic        xlate_invalidate_sync_in,
  input logic [3:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        op_busy,
  input logic        op_done,
  input logic [31:0] xlate_ea,
  input logic        xlate_req,
  input logic        xlate_is_store,
  input logic        dc_inv_req,
  input logic [1:0]  dc_new_state,
  input logic        bus_broadcast,
  input logic        dsi_exc,
  input logic        prog_illegal_exc
);
  // Broadcast enable is internal, so it is shadowed from the register writes
  reg  abe_reg;
  wire take;
  assign take = op_valid && !op_busy;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      abe_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `CMO_REG_CONFIG) begin
      abe_reg <= reg_wdata[`CMO_CFG_ABE_BIT];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_XLATE_FIRST: assert property (take && op_code == `CMO_OP_BLK_INV |=> xlate_req && xlate_ea == $past(op_ea))
    else $error("block invalidate not translated");
  AST_AS_STORE: assert property (xlate_req |-> xlate_is_store)
    else $error("translation not a store");
  AST_INV_STATE: assert property (dc_inv_req |-> dc_new_state == `CMO_ST_INVALID)
    else $error("new state not invalid");
  AST_MISS_KEEP: assert property (dc_inv_req |-> $past(dc_hit))
    else $error("invalidate on a miss");
  AST_BCAST_EN: assert property (bus_broadcast |-> abe_reg)
    else $error("broadcast while disabled");
  AST_BAT_FIRST: assert property (xlate_req && xlate_bat_hit && !xlate_bat_store_ok |=> dsi_exc && !dc_inv_req && !bus_broadcast)
    else $error("block translation fault not ranked first");
  AST_BLK_DONE: assert property (take && op_code == `CMO_OP_BLK_INV |-> ##2 op_done)
    else $error("block invalidate late");
  AST_ILLEGAL: assert property (take && op_code == `CMO_OP_TLB_INV_ALL |=> prog_illegal_exc && op_done)
    else $error("invalidate-all not illegal");
  AST_TLB_INV: assert property (take && op_code == `CMO_OP_TLB_INV |=> op_done && !op_busy)
    else $error("tlb invalidate late");
  // The sync input passes two flops, so only a level already there the cycle before the take holds the op two cycles
  AST_SYNC_STALL: assert property (take && op_code == `CMO_OP_TLB_SYNC && xlate_invalidate_sync_in |=> op_busy [*2])
    else $error("sync did not stall");
  cover property (dsi_exc);
  cover property (bus_broadcast);
  cover property (prog_illegal_exc);
  cover property (take && op_code == `CMO_OP_TLB_SYNC);
endmodule

bind cmo_maint cmo_maint_chk chk_u (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_ea(op_ea),
  .xlate_bat_hit(xlate_bat_hit), .xlate_bat_store_ok(xlate_bat_store_ok), .dc_hit(dc_hit),
  .xlate_invalidate_sync_in(xlate_invalidate_sync_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .op_busy(op_busy), .op_done(op_done), .xlate_ea(xlate_ea),
  .xlate_req(xlate_req), .xlate_is_store(xlate_is_store), .dc_inv_req(dc_inv_req), .dc_new_state(dc_new_state),
  .bus_broadcast(bus_broadcast), .dsi_exc(dsi_exc), .prog_illegal_exc(prog_illegal_exc));

/* cmo_seg_file.v */
`timescale 1ns/1ns
`include "cmo_defs.vh"

// Data and instruction-side shadow segment registers
module cmo_seg_file (
  input  wire        mclk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [3:0]  wr_idx,
  input  wire [31:0] wr_data,
  input  wire [3:0]  rd_idx,
  input  wire        rd_instr_side,
  output wire [31:0] rd_data,
  output wire [31:0] data_seg
);
  reg [31:0] dseg_reg [0:`CMO_SEG_CNT-1];
  reg [31:0] iseg_reg [0:`CMO_SEG_CNT-1];
  integer i;

  // Both copies are written together so the shadow always mirrors the data side
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `CMO_SEG_CNT; i = i + 1) begin
        dseg_reg[i] <= `CMO_ZERO32;
        iseg_reg[i] <= `CMO_ZERO32;
      end
    end else if (wr_en) begin
      dseg_reg[wr_idx] <= wr_data;
      iseg_reg[wr_idx] <= wr_data;
    end
  end

  assign rd_data  = rd_instr_side ? iseg_reg[rd_idx] : dseg_reg[rd_idx];
  assign data_seg = dseg_reg[rd_idx];
endmodule

/* cmo_tlb_valid.v */
`timescale 1ns/1ns
`include "cmo_defs.vh"

// Valid bits of both ways of both TLBs, per set
module cmo_tlb_valid (
  input  wire       mclk,
  input  wire       rst,
  input  wire       inv_en,
  input  wire [5:0] inv_set,
  input  wire       fill_en,
  input  wire [5:0] fill_set,
  input  wire [3:0] fill_ways,
  output wire [3:0] set_valid
);
  // Ways: [0] instr way0, [1] instr way1, [2] data way0, [3] data way1
  reg [3:0] valid_reg [0:`CMO_NUM_SETS-1];
  integer i;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `CMO_NUM_SETS; i = i + 1)
        valid_reg[i] <= 4'h0;
    end else begin
      if (fill_en)
        valid_reg[fill_set] <= valid_reg[fill_set] | fill_ways;
      // Invalidate listed last so it wins over a fill to the same set
      if (inv_en)
        valid_reg[inv_set] <= 4'h0;
    end
  end

  assign set_valid = valid_reg[inv_set];
endmodule
